// file: hdl/iasf_core.sv
`default_nettype none
module iasf_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire iasf_pkg::iasf_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_self_ref,
    output iasf_pkg::iasf_ram_t ram,
    input wire logic [7:0] ram_rdata,
    output logic [7:0] flags
);

    // Any virtual port address of any pointer
    function automatic logic is_port(input logic [11:0] a);
        logic [11:0] off;
        off = a - iasf_pkg::DS_PORT_BASE;
        is_port = (off[11:5] == 7'h00) && (off[4:3] != 2'b11)
            && (off[2:0] <= iasf_pkg::PORT_INDEXED);
    endfunction

    // Pointer halves, flag register or accumulator
    function automatic logic is_internal(input logic [11:0] a);
        logic [11:0] off;
        off = a - iasf_pkg::DS_PTR_BASE;
        is_internal = (off < 12'h006) || (a == iasf_pkg::DS_FLAG)
            || (a == iasf_pkg::DS_WACC);
    endfunction

    logic [11:0] ptr_r [iasf_pkg::PTR_COUNT];
    logic [11:0] ptr_nxt [iasf_pkg::PTR_COUNT];
    logic [7:0] flag_r, flag_nxt;
    logic [7:0] wacc_r, wacc_nxt;
    iasf_pkg::iasf_state_t state_r, state_nxt;
    logic [11:0] eff_r;
    iasf_pkg::iasf_op_t op_r;
    logic to_mem_r, self_r, int_r;
    iasf_pkg::iasf_ram_t ram_r, ram_nxt;
    logic rsp_valid_r;
    logic [7:0] rsp_data_r;
    logic rsp_self_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    // Request decode and effective address
    wire take_req = req_valid && (state_r == iasf_pkg::IASF_ST_IDLE);
    wire [11:0] req_off = req.addr - iasf_pkg::DS_PORT_BASE;
    wire req_hit = is_port(req.addr);
    wire [1:0] req_sel = req_off[4:3];
    wire [2:0] req_kind = req_off[2:0];
    wire [11:0] sel_ptr = (req_sel == 2'd0) ? ptr_r[0] :
        (req_sel == 2'd1) ? ptr_r[1] : ptr_r[2];
    wire [11:0] ptr_inc = sel_ptr + 12'h001;
    wire [11:0] ptr_dec = sel_ptr - 12'h001;
    wire [11:0] ptr_idx = sel_ptr + {{4{wacc_r[7]}}, wacc_r};
    wire [11:0] eff_addr = !req_hit ? req.addr :
        (req_kind == iasf_pkg::PORT_BEFORE_INC) ? ptr_inc :
        (req_kind == iasf_pkg::PORT_INDEXED) ? ptr_idx : sel_ptr;
    wire [11:0] ptr_step =
        (req_kind == iasf_pkg::PORT_AFTER_DEC) ? ptr_dec : ptr_inc;
    wire stepping = take_req && req_hit
        && (req_kind != iasf_pkg::PORT_PLAIN)
        && (req_kind != iasf_pkg::PORT_INDEXED);
    wire eff_self = req_hit && is_port(eff_addr);
    wire eff_int = is_internal(eff_addr);

    // Operand fetch
    wire in_fetch = (state_r == iasf_pkg::IASF_ST_FETCH);
    wire [11:0] int_off = eff_r - iasf_pkg::DS_PTR_BASE;
    wire [11:0] int_ptr = (int_off[2:1] == 2'd0) ? ptr_r[0] :
        (int_off[2:1] == 2'd1) ? ptr_r[1] : ptr_r[2];
    wire [7:0] int_rd = (eff_r == iasf_pkg::DS_FLAG) ? flag_r :
        (eff_r == iasf_pkg::DS_WACC) ? wacc_r :
        int_off[0] ? {4'h0, int_ptr[11:8]} : int_ptr[7:0];
    wire [7:0] opnd = self_r ? 8'h00 : int_r ? int_rd : ram_rdata;

    // Adder: subtraction adds the complement plus one
    wire is_sub = (op_r == iasf_pkg::IASF_OP_SUB);
    wire [7:0] addend = is_sub ? ~wacc_r : wacc_r;
    wire [8:0] sum = {1'b0, opnd} + {1'b0, addend}
        + {8'h00, is_sub};
    wire [4:0] nib = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]}
        + {4'h0, is_sub};
    wire wrap = (opnd[7] == addend[7]) && (sum[7] != opnd[7]);

    logic [7:0] res;
    logic [7:0] calc;
    logic upd;

    always_comb begin
        res = opnd;
        calc = flag_r;
        upd = 1'b0;
        unique case (op_r)
            iasf_pkg::IASF_OP_READ: begin
                res = opnd;
            end
            iasf_pkg::IASF_OP_WRITE: begin
                res = wacc_r;
            end
            iasf_pkg::IASF_OP_ADD, iasf_pkg::IASF_OP_SUB: begin
                res = sum[7:0];
                upd = 1'b1;
                calc[iasf_pkg::FLG_TOP_BIT] = sum[8];
                calc[iasf_pkg::FLG_NIBBLE] = nib[4];
                calc[iasf_pkg::FLG_SIGNED_WRAP] = wrap;
            end
            iasf_pkg::IASF_OP_AND: begin
                res = opnd & wacc_r;
                upd = 1'b1;
            end
            iasf_pkg::IASF_OP_IOR: begin
                res = opnd | wacc_r;
                upd = 1'b1;
            end
            iasf_pkg::IASF_OP_RLC: begin
                res = {opnd[6:0], flag_r[iasf_pkg::FLG_TOP_BIT]};
                upd = 1'b1;
                calc[iasf_pkg::FLG_TOP_BIT] = opnd[7];
                calc[iasf_pkg::FLG_NIBBLE] = opnd[3];
            end
            iasf_pkg::IASF_OP_RRC: begin
                res = {flag_r[iasf_pkg::FLG_TOP_BIT], opnd[7:1]};
                upd = 1'b1;
                calc[iasf_pkg::FLG_TOP_BIT] = opnd[0];
                calc[iasf_pkg::FLG_NIBBLE] = opnd[4];
            end
        endcase
        if (upd) begin
            calc[iasf_pkg::FLG_MSB] = res[7];
            calc[iasf_pkg::FLG_ALL_CLEAR] = (res == 8'h00);
        end
        calc = calc & iasf_pkg::FLAG_MASK;
    end

    // Result routing
    wire writes_mem = to_mem_r && (op_r != iasf_pkg::IASF_OP_READ);
    wire fetch_wr = in_fetch && writes_mem && !self_r;
    wire flag_apply = in_fetch && !(self_r && writes_mem);
    wire [7:0] flag_calc = self_r
        ? (calc | (8'h01 << iasf_pkg::FLG_ALL_CLEAR)) : calc;
    wire wr_flag = fetch_wr && (eff_r == iasf_pkg::DS_FLAG);
    wire wr_wacc = fetch_wr && (eff_r == iasf_pkg::DS_WACC);
    wire wr_ram = fetch_wr && !int_r;
    wire wacc_load = in_fetch && !to_mem_r
        && (op_r != iasf_pkg::IASF_OP_WRITE);

    // AXI4-Lite decode
    wire aw_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r
        && (state_r == iasf_pkg::IASF_ST_IDLE) && !req_valid;
    wire ar_take = s_axi_arvalid && !rvalid_r;
    wire aw_flag = (s_axi_awaddr == iasf_pkg::AXI_FLAG);
    wire aw_wacc = (s_axi_awaddr == iasf_pkg::AXI_WACC);
    wire aw_ok = aw_flag || aw_wacc
        || (s_axi_awaddr == iasf_pkg::AXI_PTR0)
        || (s_axi_awaddr == iasf_pkg::AXI_PTR1)
        || (s_axi_awaddr == iasf_pkg::AXI_PTR2)
        || (s_axi_awaddr == iasf_pkg::AXI_STAT);
    wire ar_ok = (s_axi_araddr == iasf_pkg::AXI_FLAG)
        || (s_axi_araddr == iasf_pkg::AXI_WACC)
        || (s_axi_araddr == iasf_pkg::AXI_PTR0)
        || (s_axi_araddr == iasf_pkg::AXI_PTR1)
        || (s_axi_araddr == iasf_pkg::AXI_PTR2)
        || (s_axi_araddr == iasf_pkg::AXI_STAT);
    wire busy = (state_r != iasf_pkg::IASF_ST_IDLE);
    wire [31:0] rd_mux =
        (s_axi_araddr == iasf_pkg::AXI_PTR0) ? {20'h00000, ptr_r[0]} :
        (s_axi_araddr == iasf_pkg::AXI_PTR1) ? {20'h00000, ptr_r[1]} :
        (s_axi_araddr == iasf_pkg::AXI_PTR2) ? {20'h00000, ptr_r[2]} :
        (s_axi_araddr == iasf_pkg::AXI_FLAG) ? {24'h000000, flag_r} :
        (s_axi_araddr == iasf_pkg::AXI_WACC) ? {24'h000000, wacc_r} :
        (s_axi_araddr == iasf_pkg::AXI_STAT) ? {30'h0, self_r, busy} :
        32'h00000000;

    // Pointers: bus load, stepping, then data write on top
    genvar gi;
    generate
        for (gi = 0; gi < iasf_pkg::PTR_COUNT; gi++) begin : g_ptr
            wire [7:0] aw_base = iasf_pkg::AXI_PTR0 + 8'(4 * gi);
            wire [11:0] lo_addr = iasf_pkg::DS_PTR_BASE + 12'(2 * gi);
            wire aw_hit = aw_take && (s_axi_awaddr == aw_base);
            always_comb begin
                ptr_nxt[gi] = ptr_r[gi];
                if (aw_hit && s_axi_wstrb[0]) begin
                    ptr_nxt[gi][7:0] = s_axi_wdata[7:0];
                end
                if (aw_hit && s_axi_wstrb[1]) begin
                    ptr_nxt[gi][11:8] = s_axi_wdata[11:8];
                end
                if (stepping && (req_sel == 2'(gi))) begin
                    ptr_nxt[gi] = ptr_step;
                end
                if (fetch_wr && (eff_r == lo_addr)) begin
                    ptr_nxt[gi][7:0] = res;
                end
                if (fetch_wr && (eff_r == lo_addr + 12'h001)) begin
                    ptr_nxt[gi][11:8] = res[3:0];
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ptr_r[gi] <= iasf_pkg::PTR_RESET;
                end else begin
                    ptr_r[gi] <= ptr_nxt[gi];
                end
            end
        end
    endgenerate

    // Flags and accumulator
    always_comb begin
        flag_nxt = flag_r;
        if (aw_take && aw_flag && s_axi_wstrb[0]) begin
            flag_nxt = s_axi_wdata[7:0] & iasf_pkg::FLAG_MASK;
        end
        if (flag_apply) begin
            flag_nxt = upd ? flag_calc : (flag_r | (self_r
                ? (8'h01 << iasf_pkg::FLG_ALL_CLEAR) : 8'h00));
        end
        if (wr_flag && !upd) begin
            flag_nxt = res & iasf_pkg::FLAG_MASK;
        end
    end

    always_comb begin
        wacc_nxt = wacc_r;
        if (aw_take && aw_wacc && s_axi_wstrb[0]) begin
            wacc_nxt = s_axi_wdata[7:0];
        end
        if (wr_wacc || wacc_load) begin
            wacc_nxt = res;
        end
    end

    // Sequencer and RAM port
    always_comb begin
        state_nxt = state_r;
        ram_nxt = '0;
        unique case (state_r)
            iasf_pkg::IASF_ST_IDLE: begin
                if (take_req) begin
                    state_nxt = iasf_pkg::IASF_ST_FETCH;
                    ram_nxt.en = !eff_self && !eff_int;
                    ram_nxt.addr = eff_addr;
                end
            end
            iasf_pkg::IASF_ST_FETCH: begin
                state_nxt = wr_ram ? iasf_pkg::IASF_ST_STORE
                    : iasf_pkg::IASF_ST_IDLE;
                if (wr_ram) begin
                    ram_nxt.en = 1'b1;
                    ram_nxt.we = 1'b1;
                    ram_nxt.addr = eff_r;
                    ram_nxt.wdata = res;
                end
            end
            iasf_pkg::IASF_ST_STORE: begin
                state_nxt = iasf_pkg::IASF_ST_IDLE;
            end
            default: begin
                state_nxt = iasf_pkg::IASF_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= iasf_pkg::IASF_ST_IDLE;
            flag_r <= iasf_pkg::FLAG_RESET;
            wacc_r <= iasf_pkg::WACC_RESET;
            ram_r <= '0;
        end else begin
            state_r <= state_nxt;
            flag_r <= flag_nxt;
            wacc_r <= wacc_nxt;
            ram_r <= ram_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eff_r <= 12'h000;
            op_r <= iasf_pkg::IASF_OP_READ;
            to_mem_r <= 1'b0;
            self_r <= 1'b0;
            int_r <= 1'b0;
        end else if (take_req) begin
            eff_r <= eff_addr;
            op_r <= req.op;
            to_mem_r <= req.to_mem;
            self_r <= eff_self;
            int_r <= eff_int;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
            rsp_self_r <= 1'b0;
        end else begin
            rsp_valid_r <= in_fetch;
            if (in_fetch) begin
                rsp_data_r <= res;
                rsp_self_r <= self_r;
            end
        end
    end

    // AXI4-Lite answer channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= iasf_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= iasf_pkg::RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else begin
            if (aw_take) begin
                bvalid_r <= 1'b1;
                bresp_r <= aw_ok ? iasf_pkg::RESP_OKAY
                    : iasf_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= ar_ok ? iasf_pkg::RESP_OKAY
                    : iasf_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = aw_take;
    assign s_axi_wready = aw_take;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign req_ready = !busy;
    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rsp_data_r;
    assign rsp_self_ref = rsp_self_r;
    assign ram = ram_r;
    assign flags = flag_r;

endmodule
`default_nettype wire

// file: hdl/iasf_pkg.sv
`default_nettype none
package iasf_pkg;
    localparam int PTR_COUNT = 3;

    typedef enum logic [2:0] {
        IASF_OP_READ = 3'h0,
        IASF_OP_WRITE = 3'h1,
        IASF_OP_ADD = 3'h2,
        IASF_OP_SUB = 3'h3,
        IASF_OP_AND = 3'h4,
        IASF_OP_IOR = 3'h5,
        IASF_OP_RLC = 3'h6,
        IASF_OP_RRC = 3'h7
    } iasf_op_t;

    typedef enum logic [1:0] {
        IASF_ST_IDLE = 2'b00,
        IASF_ST_FETCH = 2'b01,
        IASF_ST_STORE = 2'b11
    } iasf_state_t;

    typedef struct packed {
        logic [11:0] addr;
        iasf_op_t op;
        logic to_mem;
    } iasf_req_t;

    typedef struct packed {
        logic en;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } iasf_ram_t;

    // Port kinds: offset within a pointer's group of eight addresses
    localparam logic [2:0] PORT_PLAIN = 3'h0;
    localparam logic [2:0] PORT_AFTER_DEC = 3'h1;
    localparam logic [2:0] PORT_AFTER_INC = 3'h2;
    localparam logic [2:0] PORT_BEFORE_INC = 3'h3;
    localparam logic [2:0] PORT_INDEXED = 3'h4;

    // Data-space map of the block's own locations
    localparam logic [11:0] DS_PORT_BASE = 12'hFD0;
    localparam logic [11:0] DS_PTR_BASE = 12'hFE8;
    localparam logic [11:0] DS_FLAG = 12'hFF0;
    localparam logic [11:0] DS_WACC = 12'hFF1;

    // Flag register layout
    localparam int FLG_TOP_BIT = 0;
    localparam int FLG_NIBBLE = 1;
    localparam int FLG_ALL_CLEAR = 2;
    localparam int FLG_SIGNED_WRAP = 3;
    localparam int FLG_MSB = 4;
    localparam logic [7:0] FLAG_MASK = 8'h1F;

    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [7:0] WACC_RESET = 8'h00;

    // AXI4-Lite byte offsets
    localparam logic [7:0] AXI_PTR0 = 8'h00;
    localparam logic [7:0] AXI_PTR1 = 8'h04;
    localparam logic [7:0] AXI_PTR2 = 8'h08;
    localparam logic [7:0] AXI_FLAG = 8'h0C;
    localparam logic [7:0] AXI_WACC = 8'h10;
    localparam logic [7:0] AXI_STAT = 8'h14;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: verification/iasf_monitor.sv
`default_nettype none
module iasf_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire iasf_pkg::iasf_req_t req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_self_ref,
    input wire iasf_pkg::iasf_ram_t ram,
    input wire logic [7:0] flags
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic take = req_valid && req_ready;
    wire logic alu = |req.op[2:1];
    wire logic done = rsp_valid && !rsp_self_ref;
    wire logic selfr = rsp_valid && rsp_self_ref;

    flags_top_a: assert property (flags[7:5] == 3'h0)
        else $error("flag bits 7-5 not zero");
    rsp_time_a: assert property (take |=> !rsp_valid ##1 rsp_valid)
        else $error("response not two cycles after take");
    self_read_a: assert property (take && alu && !req.to_mem ##2 selfr
        |-> flags[2]) else $error("self read left zero flag clear");
    self_data_a: assert property (take && req.op == 3'h0 ##2 selfr
        |-> rsp_data == 8'h00) else $error("self read data not zero");
    self_write_a: assert property (take && req.to_mem && req.op != 3'h0
        ##2 selfr |-> flags == $past(flags, 2) && !ram.en)
        else $error("self write changed state");
    step_flags_a: assert property (take && req.op == 3'h0 ##2 rsp_valid
        |-> flags == ($past(flags, 2) | {5'h00, rsp_self_ref, 2'h0}))
        else $error("step changed flags");
    sign_zero_a: assert property (take && alu ##2 done
        |-> flags[4] == rsp_data[7] && flags[2] == (rsp_data == 8'h00))
        else $error("sign or zero flag wrong");
    rot_left_a: assert property (take && req.op == 3'h6 ##2 done
        |-> flags[1] == rsp_data[4]) else $error("left rotate nibble");
    rot_right_a: assert property (take && req.op == 3'h7 ##2 done
        |-> flags[1] == rsp_data[3]) else $error("right rotate nibble");
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid |=> s_axi_bvalid) else $error("write answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
endmodule

bind iasf_core iasf_monitor i_iasf_monitor (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_self_ref(rsp_self_ref), .ram(ram), .flags(flags));
`default_nettype wire

// file: verification/iasf_ram_model.sv
`default_nettype none
module iasf_ram_model (
    input wire logic aclk,
    input wire iasf_pkg::iasf_ram_t ram,
    output logic [7:0] rdata
);
    logic [7:0] mem [4096];
    // Outside a read cycle the data lines never repeat a valid byte
    assign rdata = (ram.en && !ram.we) ? mem[ram.addr] : ~mem[ram.addr];
    always @(posedge aclk) begin
        if (ram.en && ram.we) begin
            mem[ram.addr] <= ram.wdata;
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara, rsp_data, ram_rdata, flags;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [1:0] bresp, rresp;
    logic req_valid, req_ready, rsp_valid, rsp_self_ref;
    iasf_pkg::iasf_req_t req;
    iasf_pkg::iasf_ram_t ram;
    int err_count = 0;
    int total_checks = 0;
    logic [31:0] d;
    logic [7:0] q;
    logic sr;

    iasf_core i_iasf_core (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .req(req),
        .req_valid(req_valid), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_self_ref(rsp_self_ref), .ram(ram), .ram_rdata(ram_rdata),
        .flags(flags));
    iasf_ram_model i_iasf_ram_model (.aclk(aclk), .ram(ram),
        .rdata(ram_rdata));

    task automatic end_sim();
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 200) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] e = iasf_pkg::RESP_OKAY);
        int n;
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!(awr && wr) && n < 200);
        tmo(n);
        @(posedge aclk);
        awv <= 1'b0;
        wv <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!bv && n < 200);
        tmo(n);
        chk("bresp", 32'(bresp), 32'(e));
        @(posedge aclk);
        br <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
        input logic [1:0] e = iasf_pkg::RESP_OKAY);
        int n;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!arr && n < 200);
        tmo(n);
        @(posedge aclk);
        arv <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!rv && n < 200);
        tmo(n);
        v = rd;
        chk("rresp", 32'(rresp), 32'(e));
        @(posedge aclk);
        rr <= 1'b0;
    endtask
    task automatic cop(input logic [11:0] a, input logic [2:0] o,
        input logic tm);
        int n;
        @(posedge aclk);
        req <= '{addr: a, op: iasf_pkg::iasf_op_t'(o), to_mem: tm};
        req_valid <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!req_ready && n < 200);
        tmo(n);
        @(posedge aclk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!rsp_valid && n < 200);
        tmo(n);
        q = rsp_data;
        sr = rsp_self_ref;
    endtask
    function automatic logic [11:0] port(input int n, input int k);
        return iasf_pkg::DS_PORT_BASE + 12'(8 * n + k);
    endfunction

    task automatic t_regs();
        axi_rd(iasf_pkg::AXI_PTR1, d);
        chk("ptr reset", d, 32'h0);
        axi_wr(8'h18, 32'hAA, iasf_pkg::RESP_SLVERR);
        axi_rd(8'h18, d, iasf_pkg::RESP_SLVERR);
        chk("unmapped", d, 32'h0);
        axi_wr(iasf_pkg::AXI_FLAG, 32'hFF);
        axi_rd(iasf_pkg::AXI_FLAG, d);
        chk("flag upper", d, 32'h1F);
        axi_wr(iasf_pkg::AXI_PTR2, 32'hFFF);
        axi_rd(iasf_pkg::AXI_PTR2, d);
        chk("ptr width", d, 32'hFFF);
    endtask
    task automatic t_modes();
        logic [11:0] ea [5] = '{12'h100, 12'h100, 12'h100, 12'h101, 12'h0FE};
        logic [11:0] pa [5] = '{12'h100, 12'h0FF, 12'h101, 12'h101, 12'h100};
        for (int k = 0; k < 5; k++) begin
            i_iasf_ram_model.mem[ea[k]] = ea[k][7:0] ^ 8'h3C;
            axi_wr(8'(4 * (k % 3)), 32'h100);
            axi_wr(iasf_pkg::AXI_WACC, 32'hFE);
            cop(port(k % 3, k), 3'h0, 1'b1);
            chk("port data", 32'(q), 32'(ea[k][7:0] ^ 8'h3C));
            axi_rd(8'(4 * (k % 3)), d);
            chk("ptr after", d, 32'(pa[k]));
            axi_rd(iasf_pkg::AXI_WACC, d);
            chk("acc kept", d, 32'hFE);
        end
    endtask
    task automatic t_wrap();
        axi_wr(iasf_pkg::AXI_FLAG, 32'h0);
        axi_wr(iasf_pkg::AXI_PTR1, 32'hFFF);
        cop(port(1, 2), 3'h0, 1'b0);
        axi_rd(iasf_pkg::AXI_PTR1, d);
        chk("inc wrap", d, 32'h0);
        chk("step flags", 32'(flags), 32'h0);
        cop(port(1, 1), 3'h0, 1'b1);
        axi_rd(iasf_pkg::AXI_PTR1, d);
        chk("dec wrap", d, 32'hFFF);
    endtask
    task automatic t_self();
        axi_wr(iasf_pkg::AXI_FLAG, 32'h0);
        axi_wr(iasf_pkg::AXI_WACC, 32'h03);
        axi_wr(iasf_pkg::AXI_PTR2, 32'(iasf_pkg::DS_PORT_BASE));
        cop(port(2, 0), 3'h2, 1'b0);
        chk("self ref", 32'(sr), 32'h1);
        chk("self zero", 32'(flags[2]), 32'h1);
        cop(port(2, 0), 3'h0, 1'b1);
        chk("self data", 32'(q), 32'h0);
        axi_wr(iasf_pkg::AXI_FLAG, 32'h0A);
        cop(port(2, 0), 3'h2, 1'b1);
        chk("self write", 32'(flags), 32'h0A);
        axi_rd(iasf_pkg::AXI_STAT, d);
        chk("stat self", d, 32'h2);
    endtask
    task automatic t_alu();
        // Op, prior flags, operand, accumulator, result, flags
        logic [47:0] tb [9] = '{48'h02_00_7F_01_80_1A, 48'h02_00_FF_01_00_07,
            48'h03_00_05_06_FF_10, 48'h03_00_80_01_7F_09,
            48'h03_00_03_01_02_03, 48'h04_00_F0_0F_00_04,
            48'h05_0B_00_00_00_0F, 48'h06_00_88_00_10_03,
            48'h07_01_11_00_88_13};
        for (int i = 0; i < 9; i++) begin
            axi_wr(iasf_pkg::AXI_FLAG, 32'(tb[i][39:32]));
            axi_wr(iasf_pkg::AXI_WACC, 32'(tb[i][23:16]));
            i_iasf_ram_model.mem[12'h020] = tb[i][31:24];
            cop(12'h020, tb[i][42:40], 1'b0);
            chk("alu result", 32'(q), 32'(tb[i][15:8]));
            chk("alu flags", 32'(flags), 32'(tb[i][7:0]));
        end
    endtask
    task automatic t_dest();
        axi_wr(iasf_pkg::AXI_FLAG, 32'h0);
        axi_wr(iasf_pkg::AXI_WACC, 32'h80);
        cop(iasf_pkg::DS_FLAG, 3'h2, 1'b1);
        chk("flag dest", 32'(flags), 32'h10);
        axi_wr(iasf_pkg::AXI_WACC, 32'h55);
        axi_wr(iasf_pkg::AXI_PTR0, 32'(iasf_pkg::DS_PTR_BASE));
        cop(port(0, 2), 3'h1, 1'b1);
        axi_rd(iasf_pkg::AXI_PTR0, d);
        chk("write wins", d, 32'hF55);
        axi_wr(iasf_pkg::AXI_PTR0, 32'h050);
        cop(port(0, 2), 3'h1, 1'b1);
        axi_rd(iasf_pkg::AXI_PTR0, d);
        chk("store step", d, 32'h051);
        chk("ram store", 32'(i_iasf_ram_model.mem[12'h050]), 32'h55);
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {awv, wv, br, arv, rr, req_valid} = '0;
        awa = 8'h00;
        ara = 8'h00;
        wd = 32'h0;
        ws = 4'hF;
        req = '0;
        aresetn = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_wrap();
        t_self();
        t_alu();
        t_dest();
        end_sim();
    end
endmodule
`default_nettype wire
